// File: rtl/irq_mode_regs.svh
// Behaviour
// - A set DMA-request bit sends the interrupt to the DMA controller.
// - DMA bit clear: level 000 disables, 001 to 111 give priority 1 to 7.
// - DMA bit set: level 000 to 011 picks channel 0 to 3, 100 up is invalid.
// - One byte per source, source 18 serial-1 receive, 19 serial-1 transmit.
`ifndef IRQ_MODE_REGS_SVH
`define IRQ_MODE_REGS_SVH

// register byte addresses
`define MODE_REG_OFS     4'h0
`define STATUS_REG_OFS   4'h4
// first byte lane of the mode register and the source number it holds
`define FIRST_SRC_LANE   2
`define FIRST_SRC_NUM    18
// field positions inside one source byte
`define TRIG_HI_BIT      5
`define TRIG_LO_BIT      4
`define DMA_EN_BIT       3
`define LEVEL_HI_BIT     2
`define LEVEL_LO_BIT     0
// field values
`define TRIG_REQUIRED    2'h3
`define LEVEL_OFF        3'h0
`define CHAN_LIMIT       3'h4
// reset value of a source byte
`define SRC_BYTE_RST     8'h00

`endif

// File: rtl/irq_mode_pkg.sv
`default_nettype none
package irq_mode_pkg;

   // one source's control byte
   typedef struct packed {
      logic [1:0] rsvd;
      logic [1:0] trig_mode;
      logic       dma_req_en;
      logic [2:0] level;
   } src_cfg_t;

   // per-source routing toward the priority resolver and the dma controller
   typedef struct packed {
      logic       irq_req;
      logic [2:0] irq_level;
      logic       dma_req;
      logic [1:0] dma_chan;
   } src_route_t;

   typedef src_route_t [1:0] route_vec_t;

endpackage
`default_nettype wire

// File: rtl/irq_source_mode_ctrl.sv
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "irq_mode_regs.svh"
`default_nettype none
module irq_source_mode_ctrl (
   input  wire logic                    SYS_CLK_I,
   input  wire logic                    RSTN_I,
   input  wire logic [3:0]              AVS_ADDRESS_I,
   input  wire logic                    AVS_READ_I,
   input  wire logic                    AVS_WRITE_I,
   input  wire logic [31:0]             AVS_WRITEDATA_I,
   input  wire logic [3:0]              AVS_BYTEENABLE_I,
   output logic      [31:0]             AVS_READDATA_O,
   output logic                         AVS_WAITREQUEST_O,
   input  wire logic                    SER1_RX_IRQ_I,
   input  wire logic                    SER1_TX_IRQ_I,
   output irq_mode_pkg::route_vec_t     ROUTE_O,
   output logic      [3:0]              DMA_CHAN_REQ_O
);
   import irq_mode_pkg::*;

   localparam int NSRC = 2;

   src_cfg_t   cfg_q [NSRC];
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic       wait_q;
   logic [31:0] rdata_q;
   logic [31:0] mode_word;
   logic [31:0] status_word;
   logic       wr_go;
   logic       rd_go;
   route_vec_t route_d;
   logic [3:0] dma_chan_d;

   // trigger-mode field holds something other than the required code
   function automatic logic trig_bad(input src_cfg_t c);
      trig_bad = (c.trig_mode != `TRIG_REQUIRED);
   endfunction

   // dma routing with a channel number beyond the four channels
   function automatic logic chan_bad(input src_cfg_t c);
      chan_bad = c.dma_req_en && (c.level >= `CHAN_LIMIT);
   endfunction

   // request accepted in the cycle where waitrequest is low
   assign wr_go = AVS_WRITE_I && !wait_q;
   assign rd_go = AVS_READ_I && !wait_q;

   // waitrequest drops for one cycle after each request is seen
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((AVS_READ_I || AVS_WRITE_I) && wait_q);
      end
   end

   // two-stage synchroniser for the serial-1 interrupt lines
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= {SER1_TX_IRQ_I, SER1_RX_IRQ_I};
         sync2_q <= sync1_q;
      end
   end

   // read views of the mode and status registers
   always_comb begin
      mode_word   = 32'h0000_0000;
      status_word = 32'h0000_0000;
      for (int i = 0; i < NSRC; i++) begin
         mode_word[(`FIRST_SRC_LANE + i) * 8 +: 8] = cfg_q[i];
         status_word[i * 8 +: 8] = {5'h00, sync2_q[i],
                                    chan_bad(cfg_q[i]),
                                    trig_bad(cfg_q[i])};
      end
   end

   // read data is loaded as waitrequest falls
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rdata_q <= 32'h0000_0000;
      end else if (AVS_READ_I && wait_q) begin
         case (AVS_ADDRESS_I)
            `MODE_REG_OFS:   rdata_q <= mode_word;
            `STATUS_REG_OFS: rdata_q <= status_word;
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end else if (!rd_go) begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // per-source config byte, written lane by lane
   generate
      for (genvar g = 0; g < NSRC; g++) begin : g_src
         localparam int LANE = `FIRST_SRC_LANE + g;
         always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
               cfg_q[g] <= src_cfg_t'(`SRC_BYTE_RST);
            end else if (wr_go && AVS_ADDRESS_I == `MODE_REG_OFS
                         && AVS_BYTEENABLE_I[LANE]) begin
               cfg_q[g].rsvd       <= 2'h0;
               cfg_q[g].trig_mode  <= AVS_WRITEDATA_I[LANE * 8 +
                                      `TRIG_LO_BIT +: 2];
               cfg_q[g].dma_req_en <= AVS_WRITEDATA_I[LANE * 8 +
                                      `DMA_EN_BIT];
               cfg_q[g].level      <= AVS_WRITEDATA_I[LANE * 8 +
                                      `LEVEL_LO_BIT +: 3];
            end
         end
      end
   endgenerate

   // route each pending source to the processor or the dma controller
   always_comb begin
      route_d    = '0;
      dma_chan_d = 4'h0;
      for (int i = 0; i < NSRC; i++) begin
         if (!cfg_q[i].dma_req_en) begin
            route_d[i].irq_level = cfg_q[i].level;
            route_d[i].irq_req   = sync2_q[i]
                                   && (cfg_q[i].level != `LEVEL_OFF);
         end else if (!chan_bad(cfg_q[i])) begin
            route_d[i].dma_chan = cfg_q[i].level[1:0];
            route_d[i].dma_req  = sync2_q[i];
            if (sync2_q[i]) begin
               dma_chan_d[cfg_q[i].level[1:0]] = 1'b1;
            end
         end
      end
   end

   // registered routing outputs
   always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ROUTE_O        <= '0;
         DMA_CHAN_REQ_O <= 4'h0;
      end else begin
         ROUTE_O        <= route_d;
         DMA_CHAN_REQ_O <= dma_chan_d;
      end
   end

   assign AVS_READDATA_O    = rdata_q;
   assign AVS_WAITREQUEST_O = wait_q;

endmodule
`default_nettype wire

// File: bench/irq_mode_monitor.sv
`default_nettype none
module irq_mode_monitor (
   input wire logic                     SYS_CLK_I,
   input wire logic                     RSTN_I,
   input wire logic                     AVS_READ_I,
   input wire logic                     AVS_WRITE_I,
   input wire logic                     AVS_WAITREQUEST_O,
   input wire logic                     SER1_RX_IRQ_I,
   input wire logic                     SER1_TX_IRQ_I,
   input wire irq_mode_pkg::route_vec_t ROUTE_O,
   input wire logic [3:0]               DMA_CHAN_REQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] chan_or;
   // channel lines expected from the two routes
   assign chan_or = (4'(ROUTE_O[0].dma_req) << ROUTE_O[0].dma_chan)
                  | (4'(ROUTE_O[1].dma_req) << ROUTE_O[1].dma_chan);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // bus answer, routing and reset checks
   AST_ANS: assert property (
      (AVS_READ_I | AVS_WRITE_I) && AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O) else $error("bus not answered");
   AST_ONE: assert property (
      !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("wait low too long");
   AST_OFF: assert property (
      ROUTE_O[0].irq_req |-> ROUTE_O[0].irq_level != 3'h0)
      else $error("disabled source requests");
   AST_EXCL: assert property (
      ROUTE_O[1].dma_req |-> !ROUTE_O[1].irq_req)
      else $error("both paths requested");
   AST_DMAOR: assert property (DMA_CHAN_REQ_O == chan_or)
      else $error("channel lines wrong");
   AST_RX: assert property (ROUTE_O[0].irq_req | ROUTE_O[0].dma_req
      |-> $past(SER1_RX_IRQ_I, 3)) else $error("receive source crossed");
   AST_TX: assert property (ROUTE_O[1].irq_req | ROUTE_O[1].dma_req
      |-> $past(SER1_TX_IRQ_I, 3)) else $error("transmit source crossed");
   AST_RST: assert property ($rose(RSTN_I) |-> ROUTE_O == 0)
      else $error("route not clear after reset");
   cover property (ROUTE_O[0].irq_req);
   cover property (ROUTE_O[1].dma_req);
   cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
endmodule
bind irq_source_mode_ctrl irq_mode_monitor mon_u (
   .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .SER1_RX_IRQ_I(SER1_RX_IRQ_I), .SER1_TX_IRQ_I(SER1_TX_IRQ_I),
   .ROUTE_O(ROUTE_O), .DMA_CHAN_REQ_O(DMA_CHAN_REQ_O));
`default_nettype wire

// File: bench/irq_src_model.sv
`default_nettype none
module irq_src_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [1:0] want_i,
   output logic      [1:0] irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // serial channel raises its levels on the clock edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) irq_o <= 2'h0;
      else irq_o <= want_i;
   end
endmodule
`default_nettype wire

// File: bench/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_mode_pkg::*;
   logic        clk, rstn, rd, wr, wq;
   logic [3:0]  adr, be, bm, dma;
   logic [1:0]  want, irq;
   logic [31:0] wd, rdata, rdv, mode, d;
   route_vec_t  route;
   int          fail_count, comparisons;
   irq_source_mode_ctrl dut_u (.SYS_CLK_I(clk), .RSTN_I(rstn),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wq), .SER1_RX_IRQ_I(irq[0]),
      .SER1_TX_IRQ_I(irq[1]), .ROUTE_O(route), .DMA_CHAN_REQ_O(dma));
   irq_src_model src_u (.clk_i(clk), .rst_n_i(rstn), .want_i(want),
      .irq_o(irq));
   // full route of one source byte {irq_req, irq_level, dma_req, dma_chan}
   function automatic logic [6:0] rt(input logic [7:0] c, input logic x);
      logic ok;
      ok = c[3] & !c[2];
      return {x & !c[3] & (c[2:0] != 3'h0), c[3] ? 3'h0 : c[2:0],
              x & ok, ok ? c[1:0] : 2'h0};
   endfunction
   // expected channel lines and status word
   function automatic logic [35:0] side(input logic [31:0] m);
      logic [6:0] r;
      side = 0;
      for (int i = 0; i < 2; i++) begin
         side[8*i +: 3] = {want[i], m[19+8*i] & m[18+8*i],
                           m[21+8*i -: 2] != 2'h3};
         r = rt(m[16+8*i +: 8], want[i]);
         if (r[2]) side[32+m[16+8*i +: 2]] = 1;
      end
   endfunction
   task automatic chk(input logic [35:0] s, input logic [35:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
      end
   endtask
   // one bus cycle held until waitrequest is sampled low
   task automatic acc(input logic [3:0] a, input logic w,
                      input logic [31:0] x, b);
      int k;
      @(posedge clk);
      {adr, wr, rd, wd, be} <= {a, w, !w, x, b[3:0]};
      k = 0;
      do begin @(posedge clk); k++; end while (wq !== 1'b0 && k < 20);
      rdv = rdata;
      {wr, rd} <= 2'h0;
      if (k >= 20) chk(0, 1);
   endtask
   task automatic end_sim;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_sim();
   end
   // reset, then random mode bytes with corner cases first
   initial begin
      {rstn, rd, wr, adr, wd, be, want, mode} = 0;
      void'($urandom(32'h4add8fc3));
      repeat (10) @(posedge clk);
      rstn <= 1;
      acc(0, 0, 0, 15);
      chk(rdv, 0);
      $display("reset test done");
      for (int i = 0; i < 40; i++) begin
         d = $urandom | 32'h3030_0000;
         if (i == 0) d[19:16] = 0;
         if (i == 1) d[27:24] = 4'hC;
         bm = i < 2 ? 4'hC : 4'($urandom);
         acc(0, 1, d, bm);
         want <= 2'($urandom);
         for (int j = 2; j < 4; j++) if (bm[j]) mode[8*j +: 8] = d[8*j +: 8];
         repeat (5) @(posedge clk);
         chk(route[0], rt(mode[23:16], want[0]));
         chk(route[1], rt(mode[31:24], want[1]));
         chk(dma, side(mode) >> 32);
         acc(0, 0, 0, 15);
         chk(rdv, mode & 32'h3F3F_0000);
         acc(4, 1, '1, 15);
         acc(4, 0, 0, 15);
         chk(rdv, side(mode) & 32'hFFFF);
         acc(8, 1, '1, 15);
         acc(8, 0, 0, 15);
         chk(rdv, 0);
      end
      $display("random test done");
      end_sim();
   end
endmodule
`default_nettype wire
